//--- hdl/shs_perm.sv
`timescale 1ns/1ps
`include "shs_map.svh"

module shs_perm
    import shs_pkg::*;
#(
    parameter int N_MAX = 32,
    parameter int AW    = $clog2(N_MAX)
) (
    input  wire logic                   clk_sys,
    input  wire logic                   rst_n,
    input  wire logic                   clk_en,
    input  wire logic                   start,
    input  wire logic [`SHS_SEED_W-1:0] seed,
    input  wire logic [AW:0]            size,
    output logic                        done,
    input  wire logic [AW-1:0]          rd_addr,
    output logic [AW-1:0]               rd_data
);

    // =========================================================
    // Shuffle state.
    shs_pstate_type  st_q;
    shs_pstate_type  st_d;
    logic [AW-1:0]   mem [N_MAX];
    logic [AW:0]     idx_q;
    logic [31:0]     lfsr_q;
    logic [31:0]     lfsr_nx;
    logic [AW:0]     pick;
    logic [AW-1:0]   rd_q;

    generate
        if (N_MAX < 2 || (1 << AW) < N_MAX) begin : g_bad
            $error("shs_perm: N_MAX must be at least 2");
        end
    endgenerate

    assign lfsr_nx = {lfsr_q[30:0], ^(lfsr_q & `SHS_LFSR_TAPS)};
    assign pick    = (AW+1)'(lfsr_q % {{(31-AW){1'b0}}, idx_q + 1'b1});
    assign done    = (st_q == SHS_P_DONE);
    assign rd_data = rd_q;

    always_comb begin
        st_d = st_q;
        unique case (st_q)
            SHS_P_IDLE: if (start) st_d = SHS_P_FILL;
            SHS_P_FILL: if (idx_q + 1'b1 >= size) st_d = SHS_P_SHUF;
            SHS_P_SHUF: if (idx_q <= 1) st_d = SHS_P_DONE;
            SHS_P_DONE: if (start) st_d = SHS_P_FILL;
        endcase
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            st_q   <= SHS_P_IDLE;
            idx_q  <= '0;
            lfsr_q <= '0;
        end else if (clk_en) begin
            st_q <= st_d;
            if (start) begin
                idx_q  <= '0;
                lfsr_q <= {seed, `SHS_LFSR_PAD};
            end else if (st_q == SHS_P_FILL) begin
                idx_q <= (st_d == SHS_P_SHUF) ? size - 1'b1 : idx_q + 1'b1;
            end else if (st_q == SHS_P_SHUF) begin
                idx_q  <= idx_q - 1'b1;
                lfsr_q <= lfsr_nx;
            end
        end
    end

    // =========================================================
    // Identity fill, then one swap per cycle from the top down.
    always_ff @(posedge clk_sys) begin
        if (clk_en) begin
            if (st_q == SHS_P_FILL) begin
                mem[idx_q[AW-1:0]] <= idx_q[AW-1:0];
            end else if (st_q == SHS_P_SHUF && idx_q > 0) begin
                mem[idx_q[AW-1:0]] <= mem[pick[AW-1:0]];
                mem[pick[AW-1:0]]  <= mem[idx_q[AW-1:0]];
            end
            rd_q <= mem[rd_addr];
        end
    end

endmodule

//--- hdl/shs_top.sv
`timescale 1ns/1ps
`include "shs_map.svh"

// How it works
// RULE1: Off-mode value is pilot code XOR low 12 superframe bits.
// RULE2: Cell-common value swaps in superframe bits 7 to 5.
// RULE3: Previous-superframe variants use superframe index minus one.
// RULE4: Intra-cell flag picks cell-common value, else off-mode value.
// RULE5: Burst-slaved procedure only for TDD with seed field 1110.
// RULE6: Per-frame hash of carrier, subband, frame and hop value.
// RULE7: Seed is low 20 bits of the bit-reversed 32-bit hash.
// RULE8: Block-hop permutation sized to subband nonguard blocks, from the seed.
// RULE9: FL burst index is frame over frames per burst; nonzero uses current.
// RULE10: Zero FL burst uses previous-superframe value and last RL burst.
// RULE11: Slaved hash uses RL burst index in place of frame index.
// RULE12: Symbol-rate hash omits the frame term.
// RULE13: Symbol-rate block maps to initial(k + initial(k + b)) modulo size.
// RULE14: The permutation generator is a separate sub-module.
module shs_top
    import shs_pkg::*;
#(
    parameter int N_MAX = 32,
    parameter int AW    = $clog2(N_MAX)
) (
    input  wire logic          clk_sys,
    input  wire logic          rst_n,
    input  wire logic          clk_en,
    input  wire logic          start,
    input  wire shs_cfg_type   cfg,
    input  wire logic [AW:0]   nonguard_blocks,
    input  wire logic          map_req,
    input  wire logic [AW-1:0] block_idx,
    output logic               busy,
    output logic               perm_ready,
    output logic               map_ack,
    output logic [AW-1:0]      map_block,
    output shs_res_type        res
);

    generate
        if (N_MAX < 2) begin : g_bad
            $error("shs_top: N_MAX must be at least 2");
        end
    endgenerate

    // =========================================================
    // Helper functions.
    function automatic logic [11:0] make_common(input logic [11:0] off,
                                                input logic [11:0] sf);
        logic [11:0] v;
        v = off;
        v[`SHS_COMMON_HI:`SHS_COMMON_LO] =
            sf[`SHS_COMMON_HI:`SHS_COMMON_LO];
        return v;
    endfunction

    function automatic logic [AW-1:0] wrap_add(input logic [31:0] a,
                                               input logic [AW:0] n);
        return AW'(a % {{(31-AW){1'b0}}, n});
    endfunction

    // =========================================================
    // Sector values.
    shs_state_type   st_q;
    shs_state_type   st_d;
    shs_cfg_type     cfg_q;
    shs_res_type     res_q;
    logic [AW:0]     size_q;
    logic [31:0]     k_q;
    logic [AW-1:0]   map_q;
    logic            ack_q;
    logic [11:0]     sf_prev;
    logic [11:0]     p_off;
    logic [11:0]     p_on;
    logic [11:0]     p_off_m;
    logic [11:0]     p_on_m;
    logic [11:0]     p_cur;
    logic [11:0]     p_prev;
    logic [5:0]      burst_div;
    logic [5:0]      fl_burst;
    logic [5:0]      rl_last;
    logic [5:0]      rl_burst;
    logic            slaved;
    logic [11:0]     hop_value;
    logic [5:0]      frame_term;
    logic [31:0]     hash_in;
    logic [31:0]     hash;
    logic [31:0]     hash_rev;
    logic [19:0]     seed_d;
    logic [31:0]     k_d;
    logic            perm_done;
    logic [AW-1:0]   rd_addr;
    logic [AW-1:0]   rd_data;

    assign p_off   = cfg_q.sector_pilot_code ^ cfg_q.superframe_idx; // RULE1
    assign p_on    = make_common(p_off, cfg_q.superframe_idx); // RULE2
    assign sf_prev = cfg_q.superframe_idx - 12'h001; // RULE3
    assign p_off_m = cfg_q.sector_pilot_code ^ sf_prev; // RULE3
    assign p_on_m  = make_common(p_off_m, sf_prev); // RULE3
    assign p_cur   = cfg_q.intra_cell_common_hop_flag ? p_on : p_off; // RULE4
    assign p_prev  = cfg_q.intra_cell_common_hop_flag ? p_on_m : p_off_m;

    // =========================================================
    // Burst indices; a zero frames-per-burst count is taken as one.
    assign slaved = cfg_q.tdd_mode && !cfg_q.symbol_rate_hop_mode &&
                    cfg_q.sector_hop_seed_field == `SHS_SLAVED_CODE; // RULE5
    assign burst_div = (cfg_q.fl_frames_per_burst == 6'h00) ?
                       6'h01 : cfg_q.fl_frames_per_burst;
    assign fl_burst  = cfg_q.frame_idx / burst_div; // RULE9
    assign rl_last   = 6'(({1'b0, cfg_q.tdd_fl_frames_per_superframe} /
                       {2'h0, burst_div}) - 8'h01); // RULE10
    assign rl_burst  = (fl_burst != 6'h00) ?
                       fl_burst - 6'h01 : rl_last; // RULE9
    assign hop_value = (slaved && fl_burst == 6'h00) ?
                       p_prev : p_cur; // RULE10

    // =========================================================
    // Hash and seed.
    assign frame_term = cfg_q.symbol_rate_hop_mode ? 6'h00 : // RULE12
                        slaved ? rl_burst : cfg_q.frame_idx; // RULE11
    assign hash_in = 32'(cfg_q.carrier * `SHS_CARRIER_SCALE) +
                     32'(cfg_q.subband * `SHS_SUBBAND_SCALE) +
                     32'(frame_term * `SHS_FRAME_SCALE) +
                     {20'h00000, hop_value}; // RULE6
    assign hash = 32'(hash_in * `SHS_HASH_MULT); // RULE6

    genvar gi;
    generate
        for (gi = 0; gi < `SHS_HASH_W; gi++) begin : g_rev
            assign hash_rev[gi] = hash[`SHS_HASH_W-1-gi]; // RULE7
        end
    endgenerate
    assign seed_d = hash_rev[`SHS_SEED_W-1:0]; // RULE7

    // =========================================================
    // Symbol-rate offset k.
    assign k_d = 32'(cfg_q.symbols_per_fl_frame *
                 ((cfg_q.frame_idx * cfg_q.symbols_per_fl_frame) / 2 +
                  cfg_q.symbol_idx / 2)); // RULE13

    // =========================================================
    // Sequencing.
    always_comb begin
        st_d = st_q;
        unique case (st_q)
            SHS_IDLE:  if (start) st_d = SHS_LOAD;
            SHS_LOAD:  st_d = SHS_GEN;
            SHS_GEN:   if (perm_done) st_d = SHS_READY;
            SHS_READY: begin
                if (start) st_d = SHS_LOAD;
                else if (map_req) st_d = SHS_RD1;
            end
            SHS_RD1:   st_d = cfg_q.symbol_rate_hop_mode ? SHS_RD2 : SHS_READY;
            SHS_RD2:   st_d = SHS_READY;
            default:   st_d = SHS_IDLE;
        endcase
    end

    // The table is addressed in the request cycle, so the entry is ready in RD1.
    assign rd_addr = (st_q == SHS_RD1) ?
                     wrap_add(k_q + rd_data, size_q) : // RULE13
                     cfg_q.symbol_rate_hop_mode ?
                     wrap_add(k_q + block_idx, size_q) : block_idx; // RULE13

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            st_q   <= SHS_IDLE;
            cfg_q  <= '0;
            res_q  <= '0;
            size_q <= '0;
            k_q    <= '0;
            map_q  <= '0;
            ack_q  <= 1'b0;
        end else if (clk_en) begin
            st_q  <= st_d;
            ack_q <= 1'b0;
            if (start && (st_q == SHS_IDLE || st_q == SHS_READY)) begin
                cfg_q  <= cfg;
                size_q <= nonguard_blocks; // RULE8
            end
            if (st_q == SHS_LOAD) begin
                res_q <= '{seed: seed_d, hop_value: hop_value,
                           rl_burst_index: rl_burst, slaved: slaved};
                k_q   <= k_d;
            end
            if (st_q == SHS_RD1 && !cfg_q.symbol_rate_hop_mode) begin
                map_q <= rd_data; // RULE8
                ack_q <= 1'b1;
            end
            if (st_q == SHS_RD2) begin
                map_q <= rd_data; // RULE13
                ack_q <= 1'b1;
            end
        end
    end

    // =========================================================
    // Shared permutation generator.
    shs_perm #(
        .N_MAX (N_MAX),
        .AW    (AW)
    ) u_perm ( // RULE14
        .clk_sys (clk_sys),
        .rst_n   (rst_n),
        .clk_en  (clk_en),
        .start   (st_q == SHS_LOAD),
        .seed    (seed_d),
        .size    (size_q),
        .done    (perm_done),
        .rd_addr (rd_addr),
        .rd_data (rd_data)
    );

    assign busy       = (st_q == SHS_LOAD) || (st_q == SHS_GEN);
    assign perm_ready = (st_q == SHS_READY);
    assign map_ack    = ack_q;
    assign map_block  = map_q;
    assign res        = res_q;

    // =========================================================
    // Checks.
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);

    chk_off_value: assert property ( // RULE1
        st_q == SHS_LOAD && clk_en && !cfg_q.intra_cell_common_hop_flag &&
        !slaved |=> res.hop_value ==
        ($past(cfg_q.sector_pilot_code) ^ $past(cfg_q.superframe_idx)))
        else $error("off-mode hop value wrong");
    chk_common_bits: assert property ( // RULE2
        st_q == SHS_LOAD && clk_en && cfg_q.intra_cell_common_hop_flag &&
        !slaved |=> res.hop_value[7:5] == $past(cfg_q.superframe_idx[7:5]))
        else $error("cell-common bits wrong");
    chk_prev_value: assert property ( // RULE10
        st_q == SHS_LOAD && clk_en && slaved && fl_burst == 6'h00 &&
        !cfg_q.intra_cell_common_hop_flag |=> res.hop_value ==
        ($past(cfg_q.sector_pilot_code) ^ ($past(cfg_q.superframe_idx) -
        12'h001))) else $error("previous superframe value wrong");
    chk_slaved_sel: assert property ( // RULE5
        st_q == SHS_LOAD && clk_en |=> res.slaved == ($past(cfg_q.tdd_mode) &&
        !$past(cfg_q.symbol_rate_hop_mode) &&
        $past(cfg_q.sector_hop_seed_field) == 4'he))
        else $error("procedure selection wrong");
    chk_rl_burst: assert property ( // RULE9
        st_q == SHS_LOAD && clk_en && fl_burst != 6'h00 |=>
        res.rl_burst_index == $past(fl_burst) - 6'h01)
        else $error("rl burst index wrong");
    chk_seed_bits: assert property ( // RULE7
        st_q == SHS_LOAD && clk_en |=>
        res.seed[0] == $past(hash[31]) && res.seed[19] == $past(hash[12]))
        else $error("seed not bit reversed");
    chk_sym_noframe: assert property ( // RULE12
        cfg_q.symbol_rate_hop_mode |-> hash_in[17:12] == 6'h00)
        else $error("frame term in symbol-rate hash");
    chk_gen_bound: assert property ( // RULE8
        st_q == SHS_LOAD && clk_en && size_q <= (AW+1)'(N_MAX) |->
        ##[1:200] perm_ready || !clk_en || start)
        else $error("permutation not ready in time");
    chk_map_ack: assert property ( // RULE13
        st_q == SHS_READY && map_req && !start && clk_en &&
        cfg_q.symbol_rate_hop_mode ##1 clk_en[*2] |=> map_ack)
        else $error("symbol-rate lookup missing");

endmodule

//--- inc/shs_map.svh
`ifndef SHS_MAP_SVH
`define SHS_MAP_SVH

// =============================================================
// Field widths.
`define SHS_PN_W        12
`define SHS_SEED_W      20
`define SHS_HASH_W      32
`define SHS_SEED_FIELD_W 4

// =============================================================
// Cell-common bit range taken from the superframe index.
`define SHS_COMMON_HI   7
`define SHS_COMMON_LO   5

// =============================================================
// Hash scale factors and multiplier.
`define SHS_CARRIER_SCALE 32'h0040_0000
`define SHS_SUBBAND_SCALE 32'h0004_0000
`define SHS_FRAME_SCALE   32'h0000_1000
`define SHS_HASH_MULT     32'h9e37_79b1

// =============================================================
// Seed field code that selects burst-slaved hopping.
`define SHS_SLAVED_CODE 4'he

// =============================================================
// Shuffle generator constants.
`define SHS_LFSR_PAD  12'h5a5
`define SHS_LFSR_TAPS 32'h8020_0003

`endif

//--- inc/shs_pkg.sv
package shs_pkg;

    // =========================================================
    // Configuration applied at each start taken in the idle or ready state.
    typedef struct packed {
        logic [11:0] sector_pilot_code;
        logic [11:0] superframe_idx;
        logic        intra_cell_common_hop_flag;
        logic [3:0]  sector_hop_seed_field;
        logic        symbol_rate_hop_mode;
        logic        tdd_mode;
        logic [3:0]  carrier;
        logic [3:0]  subband;
        logic [5:0]  frame_idx;
        logic [3:0]  symbol_idx;
        logic [5:0]  fl_frames_per_burst;
        logic [6:0]  tdd_fl_frames_per_superframe;
        logic [3:0]  symbols_per_fl_frame;
    } shs_cfg_type;

    // =========================================================
    // Results held after each start.
    typedef struct packed {
        logic [19:0] seed;
        logic [11:0] hop_value;
        logic [5:0]  rl_burst_index;
        logic        slaved;
    } shs_res_type;

    typedef enum logic [2:0] {
        SHS_IDLE  = 3'h0,
        SHS_LOAD  = 3'h1,
        SHS_GEN   = 3'h3,
        SHS_READY = 3'h2,
        SHS_RD1   = 3'h6,
        SHS_RD2   = 3'h7
    } shs_state_type;

    typedef enum logic [1:0] {
        SHS_P_IDLE = 2'h0,
        SHS_P_FILL = 2'h1,
        SHS_P_SHUF = 2'h3,
        SHS_P_DONE = 2'h2
    } shs_pstate_type;

endpackage

//--- test/test_sector_hop_seed_gen.sv
`timescale 1ns/1ps

module test_sector_hop_seed_gen;
    import shs_pkg::*;

`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin fails++; \
    $display("mismatch at %0t: %h vs %h", $time, a, b); end end

    // =========================================================
    // Signals and design instance.
    logic        clk_sys;
    logic        rst_n;
    logic        clk_en;
    logic        start;
    logic        map_req;
    logic        busy;
    logic        perm_ready;
    logic        map_ack;
    shs_cfg_type cfg;
    logic [5:0]  nonguard_blocks;
    logic [4:0]  block_idx;
    logic [4:0]  map_block;
    shs_res_type res;
    int          fails = 0;
    int          num_checks = 0;
    int          cyc = 0;
    logic [15:0] lfsr_q = 16'h0009;
    logic [4:0]  perm [32];

    shs_top #(.N_MAX(32)) dut_u (
        .clk_sys         (clk_sys),
        .rst_n           (rst_n),
        .clk_en          (clk_en),
        .start           (start),
        .cfg             (cfg),
        .nonguard_blocks (nonguard_blocks),
        .map_req         (map_req),
        .block_idx       (block_idx),
        .busy            (busy),
        .perm_ready      (perm_ready),
        .map_ack         (map_ack),
        .map_block       (map_block),
        .res             (res)
    );

    initial begin
        clk_sys = 1'b0;
        forever #25 clk_sys = ~clk_sys;
    end

    // =========================================================
    // Reference model.
    function automatic logic [15:0] rnd();
        lfsr_q = {lfsr_q[14:0],
                  lfsr_q[15] ^ lfsr_q[13] ^ lfsr_q[12] ^ lfsr_q[10]};
        return lfsr_q;
    endfunction

    function automatic shs_res_type model(input shs_cfg_type c);
        shs_res_type r;
        logic [11:0] sf;
        logic [11:0] sfm;
        logic [11:0] off;
        logic [11:0] offm;
        logic [31:0] h;
        int          fpb;
        int          flb;
        int          fr;
        sf = c.superframe_idx;
        sfm = sf - 12'h001;
        off = c.sector_pilot_code ^ sf;
        offm = c.sector_pilot_code ^ sfm;
        r = '0;
        r.hop_value = c.intra_cell_common_hop_flag ?
            {off[11:8], sf[7:5], off[4:0]} : off;
        r.slaved = !c.symbol_rate_hop_mode && c.tdd_mode &&
            c.sector_hop_seed_field == 4'he;
        fr = c.symbol_rate_hop_mode ? 0 : int'(c.frame_idx);
        if (r.slaved) begin
            fpb = (c.fl_frames_per_burst == 6'h00) ? 1 :
                int'(c.fl_frames_per_burst);
            flb = int'(c.frame_idx) / fpb;
            r.rl_burst_index = 6'(flb - 1);
            if (flb == 0) begin
                r.hop_value = c.intra_cell_common_hop_flag ?
                    {offm[11:8], sfm[7:5], offm[4:0]} : offm;
                r.rl_burst_index =
                    6'(int'(c.tdd_fl_frames_per_superframe) / fpb - 1);
            end
            fr = int'(r.rl_burst_index);
        end
        h = (32'(c.carrier) << 22) + (32'(c.subband) << 18) +
            (32'(fr) << 12) + 32'(r.hop_value);
        h = h * 32'h9e37_79b1;
        for (int i = 0; i < 20; i++) begin
            r.seed[i] = h[31 - i];
        end
        return r;
    endfunction

    // =========================================================
    // Drivers and comparisons.
    task automatic launch(input shs_cfg_type c, input int n);
        @(posedge clk_sys);
        start <= 1'b1;
        cfg <= c;
        nonguard_blocks <= 6'(n);
        @(posedge clk_sys);
        start <= 1'b0;
    endtask

    task automatic wait_ready(input shs_cfg_type c);
        shs_res_type e;
        e = model(c);
        for (int i = 0; i < 300 && perm_ready !== 1'b1; i++) begin
            @(posedge clk_sys);
            #1;
        end
        `CHK(perm_ready, 1'b1)
        `CHK(res.seed, e.seed)
        `CHK(res.hop_value, e.hop_value)
        `CHK(res.slaved, e.slaved)
        if (e.slaved) begin
            `CHK(res.rl_burst_index, e.rl_burst_index)
        end
    endtask

    task automatic run(input shs_cfg_type c, input int n);
        launch(c, n);
        #1;
        `CHK(busy, 1'b1)
        wait_ready(c);
    endtask

    task automatic query(input int b, input int lat, output logic [4:0] m);
        int i;
        @(posedge clk_sys);
        map_req <= 1'b1;
        block_idx <= 5'(b);
        @(posedge clk_sys);
        map_req <= 1'b0;
        for (i = 1; i < 8; i++) begin
            @(posedge clk_sys);
            #1;
            if (map_ack === 1'b1) begin
                break;
            end
        end
        `CHK(i, lat)
        m = map_block;
    endtask

    task automatic perm_all(input int n, input int lat);
        logic [31:0] seen;
        logic [4:0]  m;
        seen = '0;
        for (int b = 0; b < n; b++) begin
            query(b, lat, m);
            `CHK(m < n, 1'b1)
            `CHK(seen[m], 1'b0)
            seen[m] = 1'b1;
            perm[b] = m;
        end
    endtask

    task automatic finish_test();
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    always @(posedge clk_sys) begin
        cyc++;
        if (cyc == 20000) begin
            fails++;
            $display("mismatch at %0t: timeout", $time);
            finish_test();
        end
    end

    // =========================================================
    // Main sequence.
    initial begin
        shs_cfg_type c;
        logic [4:0]  init [32];
        logic [4:0]  m;
        logic [19:0] seed0;
        int          n;
        int          k;
        rst_n = 1'b0;
        clk_en = 1'b1;
        start = 1'b0;
        map_req = 1'b0;
        cfg = '0;
        nonguard_blocks = 6'h02;
        block_idx = '0;
        repeat (16) @(posedge clk_sys);
        rst_n <= 1'b1;
        for (int i = 0; i < 8; i++) begin
            c = shs_cfg_type'(66'({rnd(), rnd(), rnd(), rnd(), rnd()}));
            c.symbol_rate_hop_mode = (i == 7);
            c.tdd_mode = (i >= 2);
            c.sector_hop_seed_field = (i == 4) ? 4'hf : 4'he;
            c.intra_cell_common_hop_flag = i[0];
            c.tdd_fl_frames_per_superframe = 7'h30;
            c.fl_frames_per_burst = (i == 5) ? 6'h00 : 6'h06;
            if (i == 2) c.frame_idx = c.frame_idx | 6'h08;
            if (i == 3) c.frame_idx = 6'h05;
            if (i == 5 || i == 6) c.frame_idx = 6'h00;
            if (i == 6) c.superframe_idx = 12'h000;
            n = (i == 0) ? 32 : 2 + int'(rnd()) % 31;
            run(c, n);
            perm_all(n, (i == 7) ? 2 : 1);
        end
        c = shs_cfg_type'(66'({rnd(), rnd(), rnd(), rnd(), rnd()}));
        c.symbol_rate_hop_mode = 1'b0;
        c.tdd_mode = 1'b0;
        c.frame_idx = 6'h00;
        n = 2 + int'(rnd()) % 31;
        run(c, n);
        seed0 = res.seed;
        perm_all(n, 1);
        for (int b = 0; b < n; b++) init[b] = perm[b];
        c.symbol_rate_hop_mode = 1'b1;
        c.frame_idx = 6'(rnd());
        run(c, n);
        `CHK(res.seed, seed0)
        k = int'(c.symbols_per_fl_frame) * (int'(c.frame_idx) *
            int'(c.symbols_per_fl_frame) / 2 + int'(c.symbol_idx) / 2);
        for (int b = 0; b < n; b++) begin
            query(b, 2, m);
            `CHK(m, init[(k + init[(k + b) % n]) % n])
        end
        c.symbol_rate_hop_mode = 1'b0;
        launch(c, n);
        clk_en <= 1'b0;
        repeat (4) @(posedge clk_sys);
        #1;
        `CHK(busy, 1'b1)
        `CHK(perm_ready, 1'b0)
        @(posedge clk_sys);
        clk_en <= 1'b1;
        start <= 1'b1;
        cfg <= ~c;
        @(posedge clk_sys);
        start <= 1'b0;
        wait_ready(c);
        launch(~c, n);
        rst_n <= 1'b0;
        repeat (2) @(posedge clk_sys);
        rst_n <= 1'b1;
        run(c, n);
        perm_all(n, 1);
        finish_test();
    end

endmodule
